// *** nvm_programming_port.sv ***
package nvm_port_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int GUARD_NS = 100;
	localparam int GUARD_CYC = (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GUARD_W = 5;
	localparam int PROG_TIME_NS = 700000;
	localparam int PROG_CYC = PROG_TIME_NS / CLK_PERIOD_NS;
	localparam int ERASE_TIME_NS = 8000000;
	localparam int ERASE_CYC = ERASE_TIME_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 21;
	localparam int FLASH_HI_W = 3;
	localparam int ADDR_W = 11;
	// Strobe action codes.
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD = 2'h2;
	// Command bit positions.
	localparam int CMD_ERASE_POS = 7;
	localparam int CMD_FUSE_POS = 6;
	localparam int CMD_LOCK_POS = 5;
	localparam int CMD_WRITE_POS = 4;
	localparam int CMD_SIG_POS = 3;
	localparam int CMD_BITS_RD_POS = 2;
	localparam int CMD_READ_POS = 1;
	localparam int CMD_TARGET_POS = 0;
	// Whole command bytes.
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
	localparam logic [7:0] CMD_FUSE_WRITE = 8'h40;
	localparam logic [7:0] CMD_LOCK_WRITE = 8'h20;
	localparam logic [7:0] CMD_FLASH_WRITE = 8'h10;
	localparam logic [7:0] CMD_EEPROM_WRITE = 8'h11;
	localparam logic [7:0] CMD_SIG_READ = 8'h08;
	localparam logic [7:0] CMD_BITS_READ = 8'h04;
	localparam logic [7:0] CMD_FLASH_READ = 8'h02;
	localparam logic [7:0] CMD_EEPROM_READ = 8'h03;
	// Data bit positions of fuse and lock bits.
	localparam int FUSE_SERIAL_POS = 5;
	localparam int FUSE_FAST_POS = 0;
	localparam int LOCK_ONE_WR_POS = 1;
	localparam int LOCK_TWO_WR_POS = 0;
	localparam int LOCK_ONE_RD_POS = 7;
	localparam int LOCK_TWO_RD_POS = 6;
	// Reset values: zero means programmed.
	localparam logic FUSE_SERIAL_RST = 1'b0;
	localparam logic FUSE_FAST_RST = 1'b1;
	localparam logic LOCK_RST = 1'b1;
	// Signature bytes; the values are arbitrary.
	localparam logic [7:0] SIG_BYTE_0 = 8'h3C;
	localparam logic [7:0] SIG_BYTE_1 = 8'h4D;
	localparam logic [7:0] SIG_BYTE_2 = 8'h5E;
	localparam logic [7:0] SIG_ADDR_0 = 8'h00;
	localparam logic [7:0] SIG_ADDR_1 = 8'h01;
	localparam logic [7:0] SIG_ADDR_2 = 8'h02;
	localparam logic [7:0] UNUSED_BYTE = 8'h00;

	typedef enum logic [1:0] {OP_FLASH, OP_EEPROM, OP_ERASE, OP_CONFIG} op_type;
	typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_TIME} seq_type;

	typedef struct packed {
		op_type op;
		logic [ADDR_W-1:0] addr;
		logic high_byte;
		logic [7:0] data;
	} nvm_req_type;

	typedef struct packed {
		logic hv_reset;
		logic crystal_input_strobe;
		logic xtal_action_1;
		logic xtal_action_0;
		logic byte_select;
		logic output_enable_n;
		logic write_pulse_n;
		logic [7:0] data;
	} prog_pins_type;

	typedef struct packed {
		logic hv_prev;
		logic [GUARD_W-1:0] guard_cnt;
		logic guard_sel;
		logic entry_fail;
		logic prog_mode;
		logic strobe_prev;
		logic wr_prev;
		logic [7:0] cmd;
		logic [7:0] addr_lo;
		logic [FLASH_HI_W-1:0] addr_hi;
		logic [7:0] data;
		logic lock_one;
		logic lock_two;
		logic fuse_serial;
		logic fuse_fast;
		logic lock_erase_pend;
		seq_type seq;
		logic [TIMER_W-1:0] timer;
		nvm_req_type req;
		logic nvm_valid;
		logic ready_busy_n;
		logic erase_done;
		logic [7:0] data_out;
		logic data_oe;
	} port_state_type;
endpackage

module nvm_programming_port #(
	parameter int PROG_CYCLES = nvm_port_pkg::PROG_CYC,
	parameter int ERASE_CYCLES = nvm_port_pkg::ERASE_CYC
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Programmer pins, data bus input half included.
	input nvm_port_pkg::prog_pins_type pins,
	// Programmer pins driven by the device.
	output logic ready_busy_n,
	output logic [7:0] parallel_data_bus_out,
	output logic parallel_data_bus_oe,
	output logic prog_mode,
	// Array write/erase request port.
	output logic nvm_valid,
	output nvm_port_pkg::nvm_req_type nvm_req,
	input wire logic nvm_ready,
	// Array read port.
	output logic [nvm_port_pkg::ADDR_W-1:0] flash_addr,
	output logic [7:0] eeprom_addr,
	input wire logic [15:0] flash_rdata,
	input wire logic [7:0] eeprom_rdata,
	// Fuse and lock state.
	output logic serial_download_fuse,
	output logic fast_startup_fuse,
	output logic lock_bit_one,
	output logic lock_bit_two
);
	import nvm_port_pkg::*;

	port_state_type st_reg;
	port_state_type st_next;
	logic strobe_rise;
	logic wr_fall;
	logic hv_rise;
	logic [1:0] action;
	logic push;
	nvm_req_type push_req;
	logic fifo_in_ready;
	logic fifo_out_valid;
	nvm_req_type fifo_out;
	logic fifo_out_ready;
	logic read_cmd;
	logic [7:0] read_byte;

	// Pins are synchronous to clk, so edges are found against last cycle.
	assign strobe_rise = pins.crystal_input_strobe && !st_reg.strobe_prev;
	assign wr_fall = !pins.write_pulse_n && st_reg.wr_prev;
	assign hv_rise = pins.hv_reset && !st_reg.hv_prev;
	assign action = {pins.xtal_action_1, pins.xtal_action_0};
	assign fifo_out_ready = st_reg.seq == ST_IDLE;
	assign read_cmd = st_reg.cmd[CMD_READ_POS] || st_reg.cmd[CMD_BITS_RD_POS] ||
		st_reg.cmd[CMD_SIG_POS];

	// The buffer decouples pin timing from the arrays; when full, no request is pushed.
	stream_fifo #(
		.WIDTH($bits(nvm_req_type)),
		.DEPTH(16)
	) req_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_valid(push),
		.in_data(push_req),
		.in_ready(fifo_in_ready),
		.out_ready(fifo_out_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out)
	);

	// Read data selection follows the loaded command.
	always_comb begin
		read_byte = UNUSED_BYTE;
		if (st_reg.cmd[CMD_READ_POS]) begin
			if (st_reg.cmd[CMD_TARGET_POS]) begin
				read_byte = eeprom_rdata;
			end else if (pins.byte_select) begin
				read_byte = flash_rdata[15:8];
			end else begin
				read_byte = flash_rdata[7:0];
			end
		end else if (st_reg.cmd[CMD_BITS_RD_POS]) begin
			read_byte[LOCK_ONE_RD_POS] = st_reg.lock_one;
			read_byte[LOCK_TWO_RD_POS] = st_reg.lock_two;
			read_byte[FUSE_SERIAL_POS] = st_reg.fuse_serial;
			read_byte[FUSE_FAST_POS] = st_reg.fuse_fast;
		end else if (st_reg.cmd[CMD_SIG_POS]) begin
			case (st_reg.addr_lo)
				SIG_ADDR_0: read_byte = SIG_BYTE_0;
				SIG_ADDR_1: read_byte = SIG_BYTE_1;
				SIG_ADDR_2: read_byte = SIG_BYTE_2;
				default: read_byte = UNUSED_BYTE;
			endcase
		end
	end

	// Next-state logic: entry guard, pin decode, sequencer, read drive.
	always_comb begin
		st_next = st_reg;
		push = 1'b0;
		push_req = '0;
		st_next.erase_done = 1'b0;
		st_next.hv_prev = pins.hv_reset;
		st_next.strobe_prev = pins.crystal_input_strobe;
		st_next.wr_prev = pins.write_pulse_n;
		// Entry waits out the guard; any byte select change during the guard blocks it
		// until the high voltage is removed and applied again.
		if (!pins.hv_reset) begin
			st_next.prog_mode = 1'b0;
			st_next.guard_cnt = '0;
			st_next.entry_fail = 1'b0;
		end else if (hv_rise) begin
			st_next.guard_cnt = GUARD_W'(GUARD_CYC);
			st_next.guard_sel = pins.byte_select;
			st_next.entry_fail = 1'b0;
		end else if (st_reg.guard_cnt != '0) begin
			st_next.guard_cnt = st_reg.guard_cnt - 1'b1;
			if (pins.byte_select != st_reg.guard_sel) begin
				st_next.entry_fail = 1'b1;
			end
			if (st_reg.guard_cnt == GUARD_W'(1) && !st_reg.entry_fail &&
				pins.byte_select == st_reg.guard_sel) begin
				st_next.prog_mode = 1'b1;
			end
		end
		// Array sequencer; clearing busy comes first so a new push wins.
		case (st_reg.seq)
			ST_IDLE: begin
				if (fifo_out_valid) begin
					st_next.req = fifo_out;
					st_next.nvm_valid = fifo_out.op != OP_CONFIG;
					st_next.seq = (fifo_out.op == OP_CONFIG) ? ST_TIME : ST_ISSUE;
					st_next.timer = (fifo_out.op == OP_ERASE) ?
						TIMER_W'(ERASE_CYCLES) : TIMER_W'(PROG_CYCLES);
				end
			end
			ST_ISSUE: begin
				if (nvm_ready) begin
					st_next.nvm_valid = 1'b0;
					st_next.seq = ST_TIME;
				end
			end
			ST_TIME: begin
				if (st_reg.timer == '0) begin
					st_next.seq = ST_IDLE;
					if (st_reg.req.op == OP_ERASE) begin
						st_next.erase_done = 1'b1;
						if (st_reg.lock_erase_pend) begin
							st_next.lock_one = 1'b1;
							st_next.lock_two = 1'b1;
							st_next.lock_erase_pend = 1'b0;
						end
					end else if (!fifo_out_valid) begin
						st_next.ready_busy_n = 1'b1;
					end
				end else begin
					st_next.timer = st_reg.timer - 1'b1;
				end
			end
			default: begin
				st_next.seq = ST_IDLE;
			end
		endcase
		// Strobe loads; command, address and data stay until reloaded.
		if (st_reg.prog_mode && strobe_rise) begin
			case (action)
				ACT_ADDR: begin
					if (pins.byte_select) begin
						st_next.addr_hi = pins.data[FLASH_HI_W-1:0];
					end else begin
						st_next.addr_lo = pins.data;
					end
				end
				ACT_DATA: begin
					st_next.data = pins.data;
				end
				ACT_CMD: begin
					st_next.cmd = pins.data;
					if (pins.data[CMD_ERASE_POS]) begin
						push_req.op = OP_ERASE;
						push = fifo_in_ready;
					end
				end
				default: begin
				end
			endcase
		end
		// Write pulse actions by command bit.
		if (st_reg.prog_mode && wr_fall) begin
			if (st_reg.cmd[CMD_ERASE_POS]) begin
				st_next.lock_erase_pend = 1'b1;
			end else if (st_reg.cmd[CMD_WRITE_POS] && st_reg.lock_one) begin
				// A programmed first lock bit blocks further array writes.
				push_req.op = st_reg.cmd[CMD_TARGET_POS] ? OP_EEPROM : OP_FLASH;
				push_req.addr = st_reg.cmd[CMD_TARGET_POS] ? ADDR_W'(st_reg.addr_lo) :
					{st_reg.addr_hi, st_reg.addr_lo};
				push_req.high_byte = pins.byte_select;
				push_req.data = st_reg.data;
				push = fifo_in_ready;
			end else if (st_reg.cmd[CMD_FUSE_POS]) begin
				st_next.fuse_serial = st_reg.data[FUSE_SERIAL_POS];
				st_next.fuse_fast = st_reg.data[FUSE_FAST_POS];
				push_req.op = OP_CONFIG;
				push = fifo_in_ready;
			end else if (st_reg.cmd[CMD_LOCK_POS]) begin
				// Lock bits only move toward programmed; erase restores them.
				st_next.lock_one = st_reg.lock_one & st_reg.data[LOCK_ONE_WR_POS];
				st_next.lock_two = st_reg.lock_two & st_reg.data[LOCK_TWO_WR_POS];
				push_req.op = OP_CONFIG;
				push = fifo_in_ready;
			end
		end
		if (push && push_req.op != OP_ERASE) begin
			st_next.ready_busy_n = 1'b0;
		end
		// Bus drive, one cycle behind the pins.
		st_next.data_oe = st_reg.prog_mode && !pins.output_enable_n && read_cmd;
		st_next.data_out = read_byte;
	end

	// Single register stage for all state.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_reg <= '0;
			st_reg.seq <= ST_IDLE;
			st_reg.req <= '0;
			st_reg.hv_prev <= 1'b0;
			st_reg.strobe_prev <= 1'b0;
			st_reg.wr_prev <= 1'b1;
			st_reg.ready_busy_n <= 1'b1;
			st_reg.lock_one <= LOCK_RST;
			st_reg.lock_two <= LOCK_RST;
			st_reg.fuse_serial <= FUSE_SERIAL_RST;
			st_reg.fuse_fast <= FUSE_FAST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from state flops.
	assign ready_busy_n = st_reg.ready_busy_n;
	assign parallel_data_bus_out = st_reg.data_out;
	assign parallel_data_bus_oe = st_reg.data_oe;
	assign prog_mode = st_reg.prog_mode;
	assign nvm_valid = st_reg.nvm_valid;
	assign nvm_req = st_reg.req;
	assign flash_addr = {st_reg.addr_hi, st_reg.addr_lo};
	assign eeprom_addr = st_reg.addr_lo;
	assign serial_download_fuse = st_reg.fuse_serial;
	assign fast_startup_fuse = st_reg.fuse_fast;
	assign lock_bit_one = st_reg.lock_one;
	assign lock_bit_two = st_reg.lock_two;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence erase_started;
		push && push_req.op == OP_ERASE && ready_busy_n;
	endsequence
	sequence ready_held;
		ready_busy_n [*8];
	endsequence

	erase_no_busy_a: assert property (erase_started |=> ready_held)
		else $error("ready_busy_n moved during chip erase");
	write_busy_a: assert property (st_reg.prog_mode && wr_fall && st_reg.cmd == CMD_FLASH_WRITE &&
		st_reg.lock_one && fifo_in_ready |=> !ready_busy_n)
		else $error("flash write did not drive busy");
	cmd_load_a: assert property (st_reg.prog_mode && strobe_rise && action == ACT_CMD
		|=> st_reg.cmd == $past(pins.data))
		else $error("command byte not loaded");
	addr_high_a: assert property (st_reg.prog_mode && strobe_rise && action == ACT_ADDR &&
		pins.byte_select |=> st_reg.addr_hi == $past(pins.data[FLASH_HI_W-1:0]))
		else $error("high address byte not loaded");
	bus_drive_a: assert property (parallel_data_bus_oe |-> $past(!pins.output_enable_n)
		&& $past(st_reg.prog_mode))
		else $error("data bus driven without enabled read");
	flash_high_a: assert property (st_reg.prog_mode && !pins.output_enable_n &&
		st_reg.cmd == CMD_FLASH_READ && pins.byte_select
		|=> parallel_data_bus_oe && parallel_data_bus_out == $past(flash_rdata[15:8]))
		else $error("flash high byte not driven");
	lock_read_a: assert property (st_reg.cmd == CMD_BITS_READ
		|=> parallel_data_bus_out[LOCK_ONE_RD_POS] == $past(st_reg.lock_one))
		else $error("lock bit one not on D7");
	fuse_write_a: assert property (st_reg.prog_mode && wr_fall && st_reg.cmd == CMD_FUSE_WRITE
		|=> serial_download_fuse == $past(st_reg.data[FUSE_SERIAL_POS]))
		else $error("serial download fuse not written");
	entry_guard_a: assert property (st_reg.guard_cnt != '0 && !hv_rise && pins.hv_reset &&
		pins.byte_select != st_reg.guard_sel |=> !prog_mode [*4])
		else $error("entry not refused after byte select change");
	lock_clear_a: assert property ($rose(lock_bit_one) |-> $past(st_reg.seq == ST_TIME &&
		st_reg.req.op == OP_ERASE && st_reg.timer == '0))
		else $error("lock bits cleared before erase end");
	eeprom_push_a: assert property (push && st_reg.cmd == CMD_EEPROM_WRITE && wr_fall
		|-> push_req.op == OP_EEPROM)
		else $error("EEPROM write sent to wrong array");
endmodule

// *** stream_fifo.sv ***
// First-in first-out buffer held in flip-flops. The pointers carry one extra
// wrap bit, so full and empty are told apart without a separate counter.
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Filling side.
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Draining side.
	input wire logic out_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} fifo_state_type;

	fifo_state_type fifo_reg;
	fifo_state_type fifo_next;
	logic full;
	logic empty;

	// Equal indices with differing wrap bits means every entry is taken.
	assign full = (fifo_reg.wr_ptr[AW] != fifo_reg.rd_ptr[AW]) &&
		(fifo_reg.wr_ptr[AW-1:0] == fifo_reg.rd_ptr[AW-1:0]);
	assign empty = fifo_reg.wr_ptr == fifo_reg.rd_ptr;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = fifo_reg.mem[fifo_reg.rd_ptr[AW-1:0]];

	// A write and a read may complete in the same cycle.
	always_comb begin
		fifo_next = fifo_reg;
		if (in_valid && !full) begin
			fifo_next.mem[fifo_reg.wr_ptr[AW-1:0]] = in_data;
			fifo_next.wr_ptr = fifo_reg.wr_ptr + 1'b1;
		end
		if (out_ready && !empty) begin
			fifo_next.rd_ptr = fifo_reg.rd_ptr + 1'b1;
		end
	end

	// Storage is cleared too, so a stray read never shows unknown data.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fifo_reg <= '0;
		end else begin
			fifo_reg <= fifo_next;
		end
	end
endmodule

// *** nvm_array_model.sv ***
// Behavioural flash and EEPROM arrays behind the port's request interface.
module nvm_array_model
	import nvm_port_pkg::*;
(
	// Clock and bench control.
	input wire logic clk,
	input wire logic slow,
	// Write and erase requests.
	input wire logic nvm_valid,
	input nvm_port_pkg::nvm_req_type nvm_req,
	output logic nvm_ready,
	// Read side.
	input wire logic [nvm_port_pkg::ADDR_W-1:0] flash_addr,
	input wire logic [7:0] eeprom_addr,
	output logic [15:0] flash_rdata,
	output logic [7:0] eeprom_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] flash_mem [2**ADDR_W];
	logic [7:0] ee_mem [256];
	logic [1:0] wait_reg = 2'h0;

	// A slow array holds the port's request for three extra cycles.
	assign nvm_ready = !slow || (wait_reg == 2'h3);
	assign flash_rdata = flash_mem[flash_addr];
	assign eeprom_rdata = ee_mem[eeprom_addr];

	// Arrays leave the factory erased.
	initial begin
		foreach (flash_mem[i]) flash_mem[i] = 16'hffff;
		foreach (ee_mem[i]) ee_mem[i] = 8'hff;
	end

	// Accepted requests update the arrays at the accepting edge.
	always @(posedge clk) begin
		wait_reg <= (nvm_valid && !nvm_ready) ? wait_reg + 2'h1 : 2'h0;
		if (nvm_valid && nvm_ready) begin
			case (nvm_req.op)
				OP_FLASH: begin
					if (nvm_req.high_byte) flash_mem[nvm_req.addr][15:8] <= nvm_req.data;
					else flash_mem[nvm_req.addr][7:0] <= nvm_req.data;
				end
				OP_EEPROM: ee_mem[nvm_req.addr[7:0]] <= nvm_req.data;
				OP_ERASE: begin
					foreach (flash_mem[i]) flash_mem[i] <= 16'hffff;
					foreach (ee_mem[i]) ee_mem[i] <= 8'hff;
				end
				default: ;
			endcase
		end
	end
endmodule

// *** parallel_nvm_programming_port_tb_top.sv ***
module parallel_nvm_programming_port_tb_top;
	import nvm_port_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PROG_N = 20;
	localparam int ERASE_N = 40;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic slow = 1'b0;
	prog_pins_type pins = 15'h0300;
	prog_pins_type pin_wire;
	logic ready_busy_n, bus_oe, prog_mode, nvm_valid, nvm_ready;
	logic serial_download_fuse, fast_startup_fuse, lock_bit_one, lock_bit_two;
	logic [7:0] bus_out, eeprom_addr, eeprom_rdata;
	logic [15:0] flash_rdata;
	logic [ADDR_W-1:0] flash_addr;
	nvm_req_type nvm_req;
	int n_errors = 0;
	int comparisons = 0;
	logic [15:0] flash_m [int];
	logic [7:0] ee_m [int];
	nvm_req_type rq [$];
	logic [7:0] sig [4] = '{SIG_BYTE_0, SIG_BYTE_1, SIG_BYTE_2, 8'h00};
	logic lk1 = 1'b1;
	logic lk2 = 1'b1;
	logic fs = 1'b0;
	logic ff = 1'b1;
	int a, w, n;

	always #2.5 clk = !clk;

	// The shared data wire carries the device's value whenever it drives.
	always_comb begin
		pin_wire = pins;
		if (bus_oe) pin_wire.data = bus_out;
	end

	nvm_programming_port #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N)) DUT (.clk, .nrst,
		.pins(pin_wire), .ready_busy_n, .parallel_data_bus_out(bus_out),
		.parallel_data_bus_oe(bus_oe), .prog_mode, .nvm_valid, .nvm_req, .nvm_ready,
		.flash_addr, .eeprom_addr, .flash_rdata, .eeprom_rdata, .serial_download_fuse,
		.fast_startup_fuse, .lock_bit_one, .lock_bit_two);
	nvm_array_model array_model (.clk, .slow, .nvm_valid, .nvm_req, .nvm_ready,
		.flash_addr, .eeprom_addr, .flash_rdata, .eeprom_rdata);

	// Every request the array accepts is kept, so the buffered path is checked end to end.
	always @(posedge clk) begin
		if (nvm_valid === 1'b1 && nvm_ready === 1'b1) rq.push_back(nvm_req);
	end

	task automatic end_of_test();
		if (n_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Inputs always move one nanosecond after the rising edge.
	task automatic tick(input int k = 1);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] d);
		{pins.xtal_action_1, pins.xtal_action_0} = act;
		pins.byte_select = bs;
		pins.data = d;
		tick();
		pins.crystal_input_strobe = 1'b1;
		tick();
		pins.crystal_input_strobe = 1'b0;
		tick();
	endtask

	// The wait for ready is bounded, so a stuck busy line fails instead of hanging.
	task automatic wpulse(input logic bs, input logic busy);
		pins.byte_select = bs;
		tick();
		pins.write_pulse_n = 1'b0;
		tick();
		pins.write_pulse_n = 1'b1;
		tick();
		chk(ready_busy_n, !busy);
		n = 0;
		while (ready_busy_n !== 1'b1 && n < 300) begin
			tick();
			n++;
		end
		chk(n inside {[PROG_N:299]}, busy);
	endtask

	task automatic rd(input logic bs, input logic [7:0] exp);
		pins.byte_select = bs;
		pins.output_enable_n = 1'b0;
		tick(2);
		chk(bus_oe, 1'b1);
		chk(bus_out, exp);
		pins.output_enable_n = 1'b1;
		tick(2);
		chk(bus_oe, 1'b0);
	endtask

	task automatic enter(input logic glitch);
		pins.hv_reset = 1'b0;
		pins.byte_select = 1'b0;
		tick(3);
		pins.hv_reset = 1'b1;
		tick(5);
		pins.byte_select = glitch;
		tick(14);
		chk(prog_mode, 1'b0);
		tick(5);
		chk(prog_mode, !glitch);
	endtask

	task automatic erase();
		load(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
		pins.write_pulse_n = 1'b0;
		tick();
		pins.write_pulse_n = 1'b1;
		for (int i = 0; i < ERASE_N + 30; i++) begin
			tick();
			chk(ready_busy_n, 1'b1);
			if (i == 10) chk({lock_bit_one, lock_bit_two}, {lk1, lk2});
		end
		flash_m.delete();
		ee_m.delete();
		{lk1, lk2} = 2'b11;
		chk({lock_bit_one, lock_bit_two, serial_download_fuse}, {lk1, lk2, fs});
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		end_of_test();
	end

	initial begin
		void'($urandom(32'hf849_ef81));
		tick(3);
		nrst = 1'b1;
		chk({ready_busy_n, bus_oe, prog_mode, nvm_valid}, 4'h8);
		chk({serial_download_fuse, fast_startup_fuse, lock_bit_one, lock_bit_two}, 4'h7);
		enter(1'b1);
		enter(1'b0);
		erase();
		// Flash words at random addresses, both halves, with a random array pace.
		load(ACT_CMD, 1'b0, CMD_FLASH_WRITE);
		for (int k = 0; k < 4; k++) begin
			a = $urandom_range(2047);
			w = $urandom;
			slow = w[16];
			load(ACT_ADDR, 1'b0, a[7:0]);
			load(ACT_ADDR, 1'b1, {5'h00, a[10:8]});
			load(ACT_DATA, 1'b0, w[7:0]);
			wpulse(1'b0, 1'b1);
			load(ACT_DATA, 1'b0, w[15:8]);
			wpulse(1'b1, 1'b1);
			flash_m[a] = w[15:0];
		end
		load(ACT_CMD, 1'b0, CMD_FLASH_READ);
		load(2'h3, 1'b0, CMD_CHIP_ERASE);
		foreach (flash_m[j]) begin
			load(ACT_ADDR, 1'b0, 8'(j));
			load(ACT_ADDR, 1'b1, 8'(j >> 8));
			rd(1'b0, flash_m[j][7:0]);
			rd(1'b1, flash_m[j][15:8]);
		end
		load(ACT_CMD, 1'b0, CMD_EEPROM_WRITE);
		for (int k = 0; k < 3; k++) begin
			a = $urandom_range(255);
			w = $urandom;
			load(ACT_ADDR, 1'b0, a[7:0]);
			load(ACT_DATA, 1'b0, w[7:0]);
			wpulse(1'b0, 1'b1);
			ee_m[a] = w[7:0];
		end
		load(ACT_CMD, 1'b0, CMD_EEPROM_READ);
		foreach (ee_m[j]) begin
			load(ACT_ADDR, 1'b0, 8'(j));
			rd(1'b0, ee_m[j]);
		end
		load(ACT_CMD, 1'b0, CMD_SIG_READ);
		for (int s = 0; s < 4; s++) begin
			load(ACT_ADDR, 1'b0, 8'(s));
			rd(1'b0, sig[s]);
		end
		// Fuses are written twice with random data; a write command never opens the bus.
		load(ACT_CMD, 1'b0, CMD_FUSE_WRITE);
		pins.output_enable_n = 1'b0;
		tick(2);
		chk(bus_oe, 1'b0);
		pins.output_enable_n = 1'b1;
		for (int k = 0; k < 2; k++) begin
			w = $urandom;
			load(ACT_DATA, 1'b0, w[7:0]);
			wpulse(1'b0, 1'b1);
			{fs, ff} = {w[5], w[0]};
			chk({serial_download_fuse, fast_startup_fuse}, {fs, ff});
		end
		for (int k = 0; k < 2; k++) begin
			load(ACT_CMD, 1'b0, CMD_LOCK_WRITE);
			load(ACT_DATA, 1'b0, k ? 8'hfe : 8'hfd);
			wpulse(1'b0, 1'b1);
			if (k) lk2 = 1'b0;
			else lk1 = 1'b0;
			chk({lock_bit_one, lock_bit_two}, {lk1, lk2});
			load(ACT_CMD, 1'b0, CMD_BITS_READ);
			rd(1'b1, {lk1, lk2, fs, 4'h0, ff});
		end
		// A programmed first lock bit refuses array writes, so no busy time follows.
		load(ACT_CMD, 1'b0, CMD_EEPROM_WRITE);
		wpulse(1'b0, 1'b0);
		erase();
		load(ACT_CMD, 1'b0, CMD_BITS_READ);
		rd(1'b1, {lk1, lk2, fs, 4'h0, ff});
		load(ACT_CMD, 1'b0, CMD_FLASH_READ);
		rd(1'b1, 8'hff);
		// One buffered write through a slow array must reach it once, intact.
		slow = 1'b1;
		load(ACT_CMD, 1'b0, CMD_FLASH_WRITE);
		a = $urandom_range(2047);
		w = $urandom;
		load(ACT_ADDR, 1'b0, a[7:0]);
		load(ACT_ADDR, 1'b1, {5'h00, a[10:8]});
		load(ACT_DATA, 1'b0, w[7:0]);
		rq.delete();
		wpulse(1'b1, 1'b1);
		chk(rq.size(), 1);
		if (rq.size() > 0) chk(32'(rq[0]), 32'({OP_FLASH, 11'(a), 1'b1, w[7:0]}));
		chk({nvm_valid, 8'(rq.size())}, 9'h001);
		end_of_test();
	end
endmodule
